/* File: pwa_pkg.sv */
// constants and types shared by the counter array pwm block
package pwa_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_CTRL = 8'hd8;
    localparam logic [7:0] IDX_COUNT = 8'hf9;
    localparam logic [2:0][7:0] IDX_CPL = {8'heb, 8'he9, 8'hfb};
    localparam logic [2:0][7:0] IDX_CPH = {8'hec, 8'hea, 8'hfc};
    localparam logic [2:0][7:0] IDX_MODE = {8'hdc, 8'hdb, 8'hda};

    // control register layout
    localparam int CTRL_CF_BIT = 7;
    localparam int CTRL_CR_BIT = 6;

    // module mode register layout
    localparam int MODE_ECOM_BIT = 6;
    localparam int MODE_PWM_BIT = 1;
    localparam int MODE_EVT_BIT = 0;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // counter wrap point
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // axi4-lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // byte lane of the word address
    localparam int ADDR_LSB = 2;

    // per-module mode bits
    typedef struct packed {
        logic comparator_enable;
        logic pwm_select;
        logic event_enable;
    } pwa_mode_t;

    localparam pwa_mode_t MODE_RST = '{1'b0, 1'b0, 1'b0};

endpackage

/* File: pwa_counter_pwm.sv */
// counter array with 8-bit pwm modules behind an axi4-lite slave
// Notes on behaviour
// - counter equals compare low sets output high
// - counter low byte overflow drives output low unless compare high is zero
// - overflow reloads compare low from compare high
// - enable and pwm select together give pwm
// - low byte write clears enable, high sets
// - high fraction is 256 minus high over 256
// - cleared enable holds output at zero duty
// - one output period per 256 counts
// - compare low byte is readable and writable
`timescale 1ns/1ps
module pwa_counter_pwm
    import pwa_pkg::*;
#(
    parameter int NUM_MODULES = 3,
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // axi4-lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // pwm pins and shared event request
    output logic [NUM_MODULES-1:0] o_module_output_pin,
    output logic o_event_request
);

    // bus state
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_have_reg, w_have_reg;
    logic [7:0] aw_idx_reg, w_data_reg;
    logic w_lane_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // block state
    logic [7:0] counter_low_byte_reg, counter_low_byte_next;
    logic counter_run_reg;
    logic counter_overflow_flag_reg;
    logic [NUM_MODULES-1:0] module_event_flag_reg, module_event_flag_next;
    logic [NUM_MODULES-1:0][7:0] compare_low_byte_reg, compare_low_byte_next;
    logic [NUM_MODULES-1:0][7:0] compare_high_byte_reg, compare_high_byte_next;
    pwa_mode_t [NUM_MODULES-1:0] mode_reg, mode_next;
    logic [NUM_MODULES-1:0] out_reg, out_next;
    logic event_request_reg;

    // decoded write
    logic wr_commit, wr_ctrl, wr_count, overflow;
    logic [NUM_MODULES-1:0] wr_cpl, wr_cph, wr_mode, match;

    // word index from a byte address
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_LSB +: 8];
    endfunction

    // true when the index names a known register
    function automatic logic index_mapped(input logic [7:0] idx);
        logic hit;
        hit = (idx == IDX_CTRL) || (idx == IDX_COUNT);
        for (int m = 0; m < NUM_MODULES; m++) begin
            hit = hit || (idx == IDX_CPL[m]) || (idx == IDX_CPH[m]) || (idx == IDX_MODE[m]);
        end
        return hit;
    endfunction

    // pwm mode is on only with both enable and select
    function automatic logic pwm_active(input pwa_mode_t md);
        return md.comparator_enable && md.pwm_select;
    endfunction

    // write commits once address and data have both arrived and lane 0 was strobed
    assign wr_commit = aw_have_reg && w_have_reg && !bvalid_reg && w_lane_reg;
    assign wr_ctrl = wr_commit && (aw_idx_reg == IDX_CTRL);
    assign wr_count = wr_commit && (aw_idx_reg == IDX_COUNT);
    assign overflow = counter_run_reg && (counter_low_byte_reg == COUNT_MAX);

    // next state of counter and modules
    always_comb begin
        counter_low_byte_next = counter_low_byte_reg;
        if (wr_count) begin
            counter_low_byte_next = w_data_reg;
        end else if (counter_run_reg) begin
            counter_low_byte_next = 8'(counter_low_byte_reg + COUNT_STEP);
        end
        for (int m = 0; m < NUM_MODULES; m++) begin
            wr_cpl[m] = wr_commit && (aw_idx_reg == IDX_CPL[m]);
            wr_cph[m] = wr_commit && (aw_idx_reg == IDX_CPH[m]);
            wr_mode[m] = wr_commit && (aw_idx_reg == IDX_MODE[m]);
            // a software write wins over the automatic reload
            compare_low_byte_next[m] = compare_low_byte_reg[m];
            if (wr_cpl[m]) begin
                compare_low_byte_next[m] = w_data_reg;
            end else if (overflow) begin
                compare_low_byte_next[m] = compare_high_byte_reg[m];
            end
            compare_high_byte_next[m] = wr_cph[m] ? w_data_reg : compare_high_byte_reg[m];
            mode_next[m] = mode_reg[m];
            if (wr_mode[m]) begin
                mode_next[m].comparator_enable = w_data_reg[MODE_ECOM_BIT];
                mode_next[m].pwm_select = w_data_reg[MODE_PWM_BIT];
                mode_next[m].event_enable = w_data_reg[MODE_EVT_BIT];
            end else if (wr_cpl[m]) begin
                mode_next[m].comparator_enable = 1'b0;
            end else if (wr_cph[m]) begin
                mode_next[m].comparator_enable = 1'b1;
            end
            match[m] = counter_run_reg && mode_reg[m].comparator_enable
                && (counter_low_byte_next == compare_low_byte_next[m]);
            // high from the match point to the wrap, so high time is 256 - high byte
            out_next[m] = pwm_active(mode_next[m])
                && (counter_low_byte_next >= compare_low_byte_next[m]);
            module_event_flag_next[m] = module_event_flag_reg[m];
            if (wr_ctrl) begin
                module_event_flag_next[m] = w_data_reg[m];
            end
            if (match[m]) begin
                module_event_flag_next[m] = 1'b1;
            end
        end
    end

    // counter and run bit
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            counter_low_byte_reg <= RST_BYTE;
            counter_run_reg <= 1'b0;
        end else begin
            counter_low_byte_reg <= counter_low_byte_next;
            if (wr_ctrl) begin
                counter_run_reg <= w_data_reg[CTRL_CR_BIT];
            end
        end
    end

    // sticky flags: a hardware set in the clearing cycle is kept
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            counter_overflow_flag_reg <= 1'b0;
            module_event_flag_reg <= '0;
            event_request_reg <= 1'b0;
        end else begin
            if (overflow) begin
                counter_overflow_flag_reg <= 1'b1;
            end else if (wr_ctrl) begin
                counter_overflow_flag_reg <= w_data_reg[CTRL_CF_BIT];
            end
            module_event_flag_reg <= module_event_flag_next;
            // the overflow flag drives the request ungated; module flags use their own enable
            event_request_reg <= counter_overflow_flag_reg
                || (|(module_event_flag_reg & mode_event_enables(mode_reg)));
        end
    end

    // gather the per-module event enables
    function automatic logic [NUM_MODULES-1:0] mode_event_enables(
        input pwa_mode_t [NUM_MODULES-1:0] md
    );
        logic [NUM_MODULES-1:0] en;
        en = '0;
        for (int m = 0; m < NUM_MODULES; m++) begin
            en[m] = md[m].event_enable;
        end
        return en;
    endfunction

    // module compare bytes, modes and pins
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            compare_low_byte_reg <= '0;
            compare_high_byte_reg <= '0;
            mode_reg <= '0;
            out_reg <= '0;
        end else begin
            compare_low_byte_reg <= compare_low_byte_next;
            compare_high_byte_reg <= compare_high_byte_next;
            mode_reg <= mode_next;
            out_reg <= out_next;
        end
    end

    // write channels: each is held until the write commits, in either order
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_idx_reg <= RST_BYTE;
            w_data_reg <= RST_BYTE;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (i_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                aw_have_reg <= 1'b1;
                aw_idx_reg <= word_index(i_awaddr);
            end else if (!aw_have_reg) begin
                awready_reg <= 1'b1;
            end
            if (i_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                w_have_reg <= 1'b1;
                w_data_reg <= i_wdata[7:0];
                w_lane_reg <= i_wstrb[0];
            end else if (!w_have_reg) begin
                wready_reg <= 1'b1;
            end
            // a write without the low lane is answered but stores nothing
            if (aw_have_reg && w_have_reg && !bvalid_reg) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= index_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && i_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (i_arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= {24'h000000, read_byte(word_index(i_araddr))};
                rresp_reg <= index_mapped(word_index(i_araddr)) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && i_rready) begin
                rvalid_reg <= 1'b0;
            end else if (!rvalid_reg) begin
                arready_reg <= 1'b1;
            end
        end
    end

    // read multiplexer; unused control bits and unmapped words read zero
    function automatic logic [7:0] read_byte(input logic [7:0] idx);
        logic [7:0] v;
        v = RST_BYTE;
        if (idx == IDX_CTRL) begin
            v[CTRL_CF_BIT] = counter_overflow_flag_reg;
            v[CTRL_CR_BIT] = counter_run_reg;
            v[NUM_MODULES-1:0] = module_event_flag_reg;
        end
        if (idx == IDX_COUNT) begin
            v = counter_low_byte_reg;
        end
        for (int m = 0; m < NUM_MODULES; m++) begin
            if (idx == IDX_CPL[m]) begin
                v = compare_low_byte_reg[m];
            end
            if (idx == IDX_CPH[m]) begin
                v = compare_high_byte_reg[m];
            end
            if (idx == IDX_MODE[m]) begin
                v[MODE_ECOM_BIT] = mode_reg[m].comparator_enable;
                v[MODE_PWM_BIT] = mode_reg[m].pwm_select;
                v[MODE_EVT_BIT] = mode_reg[m].event_enable;
            end
        end
        return v;
    endfunction

    // outputs straight from flops
    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_arready = arready_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_module_output_pin = out_reg;
    assign o_event_request = event_request_reg;

    // checks on module 0 and the shared state
    a_match_sets_high: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (counter_run_reg && !wr_commit && pwm_active(mode_reg[0]) && !overflow
        && (8'(counter_low_byte_reg + COUNT_STEP) == compare_low_byte_reg[0]))
        |=> o_module_output_pin[0])
        else $error("pin 0 not high after compare match");

    a_overflow_drives_low: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (overflow && !wr_commit && compare_high_byte_reg[0] != RST_BYTE)
        |=> !o_module_output_pin[0])
        else $error("pin 0 not low after overflow");

    a_reload_low_byte: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (overflow && !wr_commit) |=> compare_low_byte_reg[0] == $past(compare_high_byte_reg[0]))
        else $error("compare low byte not reloaded on overflow");

    a_low_write_clears: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        wr_cpl[0] |=> !mode_reg[0].comparator_enable ##1 !o_module_output_pin[0])
        else $error("low byte write did not clear enable");

    a_high_write_sets: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        wr_cph[0] |=> mode_reg[0].comparator_enable)
        else $error("high byte write did not set enable");

    a_zero_high_full: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (overflow && !wr_commit && pwm_active(mode_reg[0]) && compare_high_byte_reg[0] == RST_BYTE)
        |=> o_module_output_pin[0] ##1 (o_module_output_pin[0] || $past(wr_cpl[0] || wr_mode[0])))
        else $error("zero high byte did not give full duty");

    a_disabled_low: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!mode_reg[0].comparator_enable && !wr_commit) |=> !o_module_output_pin[0])
        else $error("disabled module drove its pin");

    a_count_wraps: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (overflow && !wr_count) |=> counter_low_byte_reg == RST_BYTE)
        else $error("counter did not wrap to zero");

    a_unused_read_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_arvalid && arready_reg && word_index(i_araddr) == IDX_CTRL)
        |=> o_rvalid && o_rdata[5:3] == 3'h0)
        else $error("unused control bits not zero");

    a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (overflow || (counter_overflow_flag_reg && !wr_ctrl)) |=> counter_overflow_flag_reg)
        else $error("overflow flag lost");

endmodule

/* File: tb_counter_array_8bit_pwm.sv */
// self-checking testbench for the counter array pwm block
`timescale 1ns/1ps
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module tb_counter_array_8bit_pwm import pwa_pkg::*;;
    // bench-driven inputs and observed outputs
    logic i_clk_sys, i_reset_n;
    logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0] i_wstrb;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_event_request;
    logic [1:0] o_bresp, o_rresp, wr_resp;
    logic [31:0] o_rdata, seed;
    logic [2:0] o_module_output_pin, prev_pin;
    logic [33:0] exp_q[$];
    logic [33:0] exp_now;
    int bad_count, checks_done;
    int ones[3], rises[3];
    logic [7:0] hi_tab[3] = '{8'h00, 8'h80, 8'hff};

    pwa_counter_pwm #(.NUM_MODULES(3), .ADDR_W(12)) pwa_counter_pwm_inst (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_module_output_pin(o_module_output_pin), .o_event_request(o_event_request)
    );

    // 40 mhz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    // fixed-seed pseudo random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // prints counts and verdict, then stops the run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // axi write; handshakes sampled at negedge so no edge race with the slave
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic aw_hs, w_hs, b_hs;
        b_hs = 1'b0;
        i_awaddr <= {2'b00, idx, 2'b00};
        i_wdata <= {24'h000000, val};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!b_hs) begin
            @(negedge i_clk_sys);
            aw_hs = i_awvalid && o_awready;
            w_hs = i_wvalid && o_wready;
            b_hs = o_bvalid;
            wr_resp = o_bresp;
            @(posedge i_clk_sys);
            if (aw_hs) i_awvalid <= 1'b0;
            if (w_hs) i_wvalid <= 1'b0;
        end
        i_bready <= 1'b0;
        @(posedge i_clk_sys); // spare edge so bready never toggles twice in one step
    endtask

    // axi read; expected {resp, data} is noted for the monitor
    task automatic rd(input logic [7:0] idx, input logic [33:0] exp);
        logic ar_hs, r_hs;
        r_hs = 1'b0;
        exp_q.push_back(exp);
        i_araddr <= {2'b00, idx, 2'b00};
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while (!r_hs) begin
            @(negedge i_clk_sys);
            ar_hs = i_arvalid && o_arready;
            r_hs = o_rvalid;
            @(posedge i_clk_sys);
            if (ar_hs) i_arvalid <= 1'b0;
        end
        i_rready <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    // monitor: each accepted read beat is checked against the oldest note
    always @(negedge i_clk_sys) begin
        if (i_reset_n && o_rvalid && i_rready) begin
            exp_now = exp_q.pop_front();
            `CHK({o_rresp, o_rdata}, exp_now)
        end
    end

    // counts high cycles and rising edges of each pin over one 256-count span
    task automatic measure();
        for (int m = 0; m < 3; m++) begin
            ones[m] = 0;
            rises[m] = 0;
        end
        @(negedge i_clk_sys);
        prev_pin = o_module_output_pin;
        repeat (256) begin
            @(negedge i_clk_sys);
            for (int m = 0; m < 3; m++) begin
                if (o_module_output_pin[m] === 1'b1) ones[m]++;
                if (o_module_output_pin[m] === 1'b1 && prev_pin[m] === 1'b0) rises[m]++;
            end
            prev_pin = o_module_output_pin;
        end
        @(posedge i_clk_sys);
    endtask

    // watchdog: the whole sequence needs about a thousand cycles
    initial begin
        repeat (12000) @(posedge i_clk_sys);
        $display("watchdog expired");
        bad_count++;
        conclude();
    end

    // main sequence
    initial begin
        i_reset_n = 1'b0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        i_awaddr = 12'h000;
        i_araddr = 12'h000;
        i_wdata = 32'h00000000;
        i_wstrb = 4'h1; // only lane 0 carries a register byte
        seed = 32'h64ef;
        repeat (6) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_clk_sys);

        // reset values and an unmapped place
        rd(IDX_CTRL, {RESP_OKAY, 32'h00000000});
        for (int m = 0; m < 3; m++) rd(IDX_CPL[m], {RESP_OKAY, 32'h00000000});
        rd(8'h00, {RESP_SLVERR, 32'h00000000});
        wr(8'h00, 8'h5a);
        `CHK(wr_resp, RESP_SLVERR)
        $display("test reset_values done");

        // low byte write clears enable, high byte write sets it
        for (int m = 0; m < 3; m++) begin
            seed = lfsr(seed);
            wr(IDX_MODE[m], 8'h42); // enable set first so the low byte write must clear it
            wr(IDX_CPL[m], seed[7:0]);
            rd(IDX_CPL[m], {RESP_OKAY, 24'h000000, seed[7:0]});
            rd(IDX_MODE[m], {RESP_OKAY, 32'h00000002});
            wr(IDX_CPH[m], hi_tab[m]);
            rd(IDX_MODE[m], {RESP_OKAY, 32'h00000042});
        end
        $display("test compare_setup done");

        // run; warm up past one overflow so every low byte has reloaded
        wr(IDX_CTRL, 8'h40);
        repeat (300) @(posedge i_clk_sys);
        rd(IDX_CPL[1], {RESP_OKAY, 32'h00000080});
        measure();
        for (int m = 0; m < 3; m++) begin
            `CHK(ones[m], 256 - int'(hi_tab[m]))
            `CHK(rises[m], (hi_tab[m] == 8'h00) ? 0 : 1)
        end
        rd(IDX_CTRL, {RESP_OKAY, 32'h000000c7});
        `CHK(o_event_request, 1'b1)
        $display("test duty_cycle done");

        // a low byte write alone leaves the module disabled at zero duty
        wr(IDX_CPL[0], 8'h00);
        repeat (2) @(posedge i_clk_sys);
        measure();
        `CHK(ones[0], 0)
        `CHK(ones[1], 128)
        $display("test zero_duty done");

        // stop the counter, clear flags, unused bits read zero
        wr(IDX_CTRL, 8'h00);
        wr(IDX_COUNT, 8'h55);
        i_wstrb <= 4'h0;
        wr(IDX_COUNT, 8'haa); // no lane 0: answered, nothing stored
        i_wstrb <= 4'h1;
        `CHK(wr_resp, RESP_OKAY)
        repeat (20) @(posedge i_clk_sys);
        rd(IDX_COUNT, {RESP_OKAY, 32'h00000055});
        // a module flag reaches the request only through its event enable
        wr(IDX_CTRL, 8'h02);
        `CHK(o_event_request, 1'b0)
        wr(IDX_MODE[1], 8'h43);
        rd(IDX_MODE[1], {RESP_OKAY, 32'h00000043});
        `CHK(o_event_request, 1'b1)
        wr(IDX_CTRL, 8'h38);
        rd(IDX_CTRL, {RESP_OKAY, 32'h00000000});
        `CHK(o_event_request, 1'b0)
        $display("test control_bits done");
        conclude();
    end
endmodule
